// file: logic/fcp_cfg.svh
// Addresses, field positions, reset values and fixed gains of the current path.
// Assumes an 8-bit special-function register bus with 16-bit addresses.
`ifndef FCP_CFG_SVH
`define FCP_CFG_SVH
`define FCP_A_CMD_LO   16'h00a6
`define FCP_A_CMD_HI   16'h00a7
`define FCP_A_OUT_LO   16'h00ac
`define FCP_A_OUT_HI   16'h00ad
`define FCP_A_FB_LO    16'h00ae
`define FCP_A_FB_HI    16'h00af
`define FCP_A_MC1      16'h00bf
`define FCP_A_FOC      16'h00d6
`define FCP_A_PAGE     16'h00ec
`define FCP_A_PHB_LO   16'h1058
`define FCP_A_PHB_HI   16'h1059
`define FCP_A_BETA_LO  16'h105a
`define FCP_A_BETA_HI  16'h105b
`define FCP_A_PHA_LO   16'h1060
`define FCP_A_PHA_HI   16'h1061
`define FCP_A_ALPHA_LO 16'h1062
`define FCP_A_ALPHA_HI 16'h1063
`define FCP_MC1_QSRC   4
`define FCP_FOC_CLEAR  7
`define FCP_FOC_SC_HI  6
`define FCP_FOC_SC_LO  4
`define FCP_PAGE_Q     8'h00
`define FCP_PAGE_D     8'h01
`define FCP_RST_CMD    16'h0000
`define FCP_RST_REG    8'h00
`define FCP_RST_PAGE   8'h00
`define FCP_INV_SQRT3  16'sh49e7
`define FCP_KP         16'sh2000
`define FCP_KI         16'sh0400
`define FCP_QSHIFT     15
`define FCP_MAX        34'sh0_0000_7fff
`define FCP_MIN        -34'sh0_0000_8000
`endif

// file: logic/fcp_pkg.sv
// Types shared by the current path: data word and the registered state.
// Assumes fcp_cfg.svh supplies every address and constant.
`default_nettype none
package fcp_pkg;
    typedef logic signed [15:0] fcp_word_t;
    typedef struct packed {
        logic [7:0] page;
        logic [7:0] mc1;
        logic [7:0] foc;
        fcp_word_t  cmd_d;
        fcp_word_t  cmd_q;
        fcp_word_t  pha;
        fcp_word_t  phb;
        fcp_word_t  alpha;
        fcp_word_t  beta;
        fcp_word_t  sin_v;
        fcp_word_t  cos_v;
        fcp_word_t  id;
        fcp_word_t  iq;
        fcp_word_t  integ_d;
        fcp_word_t  integ_q;
        fcp_word_t  vd;
        fcp_word_t  vq;
        fcp_word_t  est_a;
        fcp_word_t  est_b;
        logic [7:0] rdata;
        logic       vld1;
        logic       vld2;
        logic       vld3;
    } fcp_state_s;
endpackage
`default_nettype wire

// file: logic/fcp_current_path.sv
// Forward current path: Clarke, Park, d/q PI current loop and its registers.
// Assumes ADC samples, rotor angle and speed-loop output arrive on clk.
`include "fcp_cfg.svh"
`default_nettype none
// Overview of operation
// RULE_01: Convert phase A and B currents to stationary alpha and beta.
// RULE_02: Rotate alpha and beta into d and q using rotor angle.
// RULE_03: Control bits 6..4 scale estimator currents by x1..x8 or /2../16.
// RULE_04: Phase A and phase B raw currents readable as byte pairs.
// RULE_05: Alpha and beta currents readable as byte pairs.
// RULE_06: Feedback pair returns q current on page 0, d on page 1.
// RULE_07: Software selects the page before touching a paged pair.
// RULE_08: Current loop has a command mux and two separate PI controllers.
// RULE_09: PI law acts on command minus Park feedback, giving d/q voltages.
// RULE_10: Command pair on page 1 holds d command, reset zero.
// RULE_11: Command pair on page 0 holds q command, reset zero.
// RULE_12: Motor control bit 4 picks software or speed-loop q command.
// RULE_13: Motor control and field control registers reset to zero.
// RULE_14: Output pair returns q voltage on page 0, d on page 1.
// RULE_15: Low byte holds bits 7..0, next address bits 15..8.
// RULE_16: Paged pairs decode the page on every read and write.
module fcp_current_path (
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic [15:0]       sfr_addr,
    input  wire logic              sfr_wr,
    input  wire logic              sfr_rd,
    input  wire logic [7:0]        sfr_wdata,
    output logic      [7:0]        sfr_rdata,
    input  wire logic              sample_valid,
    input  wire fcp_pkg::fcp_word_t phase_a_in,
    input  wire fcp_pkg::fcp_word_t phase_b_in,
    input  wire logic [15:0]       rotor_angle,
    input  wire fcp_pkg::fcp_word_t speed_loop_out,
    output fcp_pkg::fcp_word_t     d_axis_voltage,
    output fcp_pkg::fcp_word_t     q_axis_voltage,
    output logic                   voltage_valid,
    output fcp_pkg::fcp_word_t     est_alpha,
    output fcp_pkg::fcp_word_t     est_beta,
    output logic                   est_valid,
    output logic      [7:0]        motor_control_one,
    output logic      [7:0]        field_oriented_control
);
    import fcp_pkg::*;

    localparam fcp_state_s RST_ST = '{
        page:    `FCP_RST_PAGE,
        mc1:     `FCP_RST_REG,
        foc:     `FCP_RST_REG,
        cmd_d:   `FCP_RST_CMD,
        cmd_q:   `FCP_RST_CMD,
        default: '0
    };

    fcp_state_s st;
    fcp_state_s next_st;

    logic signed [17:0] clarke_sum;
    logic signed [33:0] clarke_prod;
    logic signed [33:0] park_d;
    logic signed [33:0] park_q;
    fcp_word_t          q_ref;
    fcp_word_t          err_d;
    fcp_word_t          err_q;
    fcp_word_t          int_d;
    fcp_word_t          int_q;
    logic               is_page_q;
    logic               is_page_d;

    // Saturate rather than wrap so a large error never flips the voltage sign
    function automatic fcp_word_t sat16(input logic signed [33:0] x);
        if (x > `FCP_MAX) begin
            return 16'sh7fff;
        end else if (x < `FCP_MIN) begin
            return 16'sh8000;
        end
        return x[15:0];
    endfunction

    function automatic fcp_word_t mulq(input fcp_word_t a, input fcp_word_t b);
        logic signed [33:0] p;
        p = 34'(a) * 34'(b);
        return sat16(p >>> `FCP_QSHIFT);
    endfunction

    // Quarter-wave table, 16 steps per quadrant; coarse but cheap
    function automatic fcp_word_t sin_lut(input logic [15:0] ang);
        logic [4:0] i;
        fcp_word_t  m;
        i = ang[14] ? 5'h10 - {1'b0, ang[13:10]} : {1'b0, ang[13:10]};
        unique case (i)
            5'h00: m = 16'sh0000;
            5'h01: m = 16'sh0c8c;
            5'h02: m = 16'sh18f9;
            5'h03: m = 16'sh2528;
            5'h04: m = 16'sh30fc;
            5'h05: m = 16'sh3c57;
            5'h06: m = 16'sh471d;
            5'h07: m = 16'sh5134;
            5'h08: m = 16'sh5a82;
            5'h09: m = 16'sh62f2;
            5'h0a: m = 16'sh6a6e;
            5'h0b: m = 16'sh70e3;
            5'h0c: m = 16'sh7642;
            5'h0d: m = 16'sh7a7d;
            5'h0e: m = 16'sh7d8a;
            5'h0f: m = 16'sh7f62;
            5'h10: m = 16'sh7fff;
            default: m = 16'sh0000;
        endcase
        return ang[15] ? -m : m;
    endfunction

    function automatic fcp_word_t scale(input fcp_word_t x, input logic [2:0] c);
        if (c[2]) begin
            return x >>> ({1'b0, c[1:0]} + 3'h1);
        end
        return sat16(34'(x) <<< c[1:0]);
    endfunction

    function automatic logic [7:0] pick(input fcp_word_t w, input logic hi);
        return hi ? w[15:8] : w[7:0];
    endfunction

    always_comb begin
        next_st = st;
        is_page_q = st.page == `FCP_PAGE_Q;
        is_page_d = st.page == `FCP_PAGE_D;
        clarke_sum = 18'(phase_a_in) + (18'(phase_b_in) <<< 1);
        clarke_prod = 34'(clarke_sum) * 34'(`FCP_INV_SQRT3);
        park_d = 34'(st.alpha) * 34'(st.cos_v) + 34'(st.beta) * 34'(st.sin_v);
        park_q = 34'(st.beta) * 34'(st.cos_v) - 34'(st.alpha) * 34'(st.sin_v);
        q_ref = st.mc1[`FCP_MC1_QSRC] ? speed_loop_out : st.cmd_q; // RULE_12 RULE_08
        err_d = sat16(34'(st.cmd_d) - 34'(st.id)); // RULE_09
        err_q = sat16(34'(q_ref) - 34'(st.iq)); // RULE_09
        int_d = sat16(34'(st.integ_d) + 34'(mulq(`FCP_KI, err_d)));
        int_q = sat16(34'(st.integ_q) + 34'(mulq(`FCP_KI, err_q)));
        next_st.vld1 = sample_valid;
        next_st.vld2 = st.vld1;
        next_st.vld3 = st.vld2;
        if (sample_valid) begin
            next_st.pha = phase_a_in;
            next_st.phb = phase_b_in;
            next_st.alpha = phase_a_in; // RULE_01
            next_st.beta = sat16(clarke_prod >>> `FCP_QSHIFT); // RULE_01
            next_st.sin_v = sin_lut(rotor_angle);
            next_st.cos_v = sin_lut(rotor_angle + 16'h4000);
        end
        if (st.vld1) begin
            next_st.id = sat16(park_d >>> `FCP_QSHIFT); // RULE_02
            next_st.iq = sat16(park_q >>> `FCP_QSHIFT); // RULE_02
            next_st.est_a = scale(st.alpha, st.foc[`FCP_FOC_SC_HI:`FCP_FOC_SC_LO]); // RULE_03
            next_st.est_b = scale(st.beta, st.foc[`FCP_FOC_SC_HI:`FCP_FOC_SC_LO]); // RULE_03
        end
        if (st.vld2) begin
            next_st.integ_d = int_d; // RULE_08
            next_st.integ_q = int_q; // RULE_08
            next_st.vd = sat16(34'(mulq(`FCP_KP, err_d)) + 34'(int_d)); // RULE_09
            next_st.vq = sat16(34'(mulq(`FCP_KP, err_q)) + 34'(int_q)); // RULE_09
        end
        // Clear bit holds both integrators at zero while it stays set
        if (st.foc[`FCP_FOC_CLEAR]) begin
            next_st.integ_d = '0;
            next_st.integ_q = '0;
        end
        if (sfr_wr) begin
            unique case (sfr_addr)
                `FCP_A_PAGE: next_st.page = sfr_wdata;
                `FCP_A_MC1:  next_st.mc1 = sfr_wdata;
                `FCP_A_FOC:  next_st.foc = sfr_wdata;
                `FCP_A_CMD_LO: begin
                    if (is_page_d) begin
                        next_st.cmd_d[7:0] = sfr_wdata; // RULE_10 RULE_15 RULE_16
                    end else if (is_page_q) begin
                        next_st.cmd_q[7:0] = sfr_wdata; // RULE_11 RULE_15 RULE_16
                    end
                end
                `FCP_A_CMD_HI: begin
                    if (is_page_d) begin
                        next_st.cmd_d[15:8] = sfr_wdata; // RULE_10 RULE_15 RULE_16
                    end else if (is_page_q) begin
                        next_st.cmd_q[15:8] = sfr_wdata; // RULE_11 RULE_15 RULE_16
                    end
                end
                default: ;
            endcase
        end
        // Unmapped addresses and unused pages read as zero
        if (sfr_rd) begin
            next_st.rdata = 8'h00;
            unique case (sfr_addr)
                `FCP_A_PAGE: next_st.rdata = st.page;
                `FCP_A_MC1:  next_st.rdata = st.mc1;
                `FCP_A_FOC:  next_st.rdata = st.foc;
                `FCP_A_CMD_LO, `FCP_A_CMD_HI: begin
                    if (is_page_d) begin
                        next_st.rdata = pick(st.cmd_d, sfr_addr[0]); // RULE_10 RULE_16
                    end else if (is_page_q) begin
                        next_st.rdata = pick(st.cmd_q, sfr_addr[0]); // RULE_11 RULE_16
                    end
                end
                `FCP_A_FB_LO, `FCP_A_FB_HI: begin
                    if (is_page_d) begin
                        next_st.rdata = pick(st.id, sfr_addr[0]); // RULE_06 RULE_16
                    end else if (is_page_q) begin
                        next_st.rdata = pick(st.iq, sfr_addr[0]); // RULE_06 RULE_16
                    end
                end
                `FCP_A_OUT_LO, `FCP_A_OUT_HI: begin
                    if (is_page_d) begin
                        next_st.rdata = pick(st.vd, sfr_addr[0]); // RULE_14 RULE_16
                    end else if (is_page_q) begin
                        next_st.rdata = pick(st.vq, sfr_addr[0]); // RULE_14 RULE_16
                    end
                end
                `FCP_A_PHA_LO, `FCP_A_PHA_HI: next_st.rdata = pick(st.pha, sfr_addr[0]); // RULE_04
                `FCP_A_PHB_LO, `FCP_A_PHB_HI: next_st.rdata = pick(st.phb, sfr_addr[0]); // RULE_04
                `FCP_A_ALPHA_LO, `FCP_A_ALPHA_HI: begin
                    next_st.rdata = pick(st.alpha, sfr_addr[0]); // RULE_05 RULE_15
                end
                `FCP_A_BETA_LO, `FCP_A_BETA_HI: begin
                    next_st.rdata = pick(st.beta, sfr_addr[0]); // RULE_05 RULE_15
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st <= RST_ST; // RULE_13 RULE_10 RULE_11
        end else begin
            st <= next_st;
        end
    end

    assign sfr_rdata = st.rdata;
    assign d_axis_voltage = st.vd;
    assign q_axis_voltage = st.vq;
    assign voltage_valid = st.vld3;
    assign est_alpha = st.est_a;
    assign est_beta = st.est_b;
    assign est_valid = st.vld2;
    assign motor_control_one = st.mc1;
    assign field_oriented_control = st.foc;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence rd_fb_q;
        sfr_rd && sfr_addr == `FCP_A_FB_LO && st.page == `FCP_PAGE_Q;
    endsequence
    sequence rd_out_d;
        sfr_rd && sfr_addr == `FCP_A_OUT_HI && st.page == `FCP_PAGE_D;
    endsequence
    sequence wr_cmd_d;
        sfr_wr && sfr_addr == `FCP_A_CMD_LO && st.page == `FCP_PAGE_D;
    endsequence

    clarke_alpha_a: assert property ( // RULE_01
        sample_valid |=> st.alpha == $past(phase_a_in) ##2 st.vld3)
        else $error("alpha not taken from phase A");
    park_zero_a: assert property ( // RULE_02
        sample_valid && rotor_angle == 16'h0000 && phase_b_in == 16'sh0000
        |=> ##1 st.id == $past(phase_a_in, 2) - (($past(phase_a_in, 2) > 0) ? 16'sh0001 : 16'sh0000))
        else $error("park d current wrong at zero angle");
    est_div2_a: assert property ( // RULE_03
        st.vld1 && st.foc[6:4] == 3'h4 |=> st.est_a == ($past(st.alpha) >>> 1))
        else $error("estimator divide by two wrong");
    rd_alpha_a: assert property ( // RULE_05
        sfr_rd && sfr_addr == `FCP_A_ALPHA_HI |=> sfr_rdata == $past(st.alpha[15:8]))
        else $error("alpha high byte read wrong");
    fb_page_q_a: assert property ( // RULE_06
        rd_fb_q |=> sfr_rdata == $past(st.iq[7:0]))
        else $error("q feedback read wrong");
    out_page_d_a: assert property ( // RULE_14
        rd_out_d |=> sfr_rdata == $past(st.vd[15:8]))
        else $error("d voltage read wrong");
    cmd_d_write_a: assert property ( // RULE_10
        wr_cmd_d |=> st.cmd_d[7:0] == $past(sfr_wdata) && $stable(st.cmd_q))
        else $error("d command write misrouted");
    q_source_a: assert property ( // RULE_12
        st.mc1[4] && st.foc[7] && st.vld2 && st.iq == 16'sh0000
        && speed_loop_out == 16'sh0000 |=> st.vq == 16'sh0000)
        else $error("q source select ignored");
    pi_clear_a: assert property ( // RULE_09
        st.foc[7] |=> st.integ_d == 16'sh0000 && st.integ_q == 16'sh0000)
        else $error("integrators not cleared");
endmodule
`default_nettype wire

// file: tb/fcp_cpu_model.sv
// Processor-side model: byte accesses on the special-function register bus.
// Assumes the bench calls its tasks only after reset has been released.
`include "fcp_cfg.svh"
`default_nettype none
module fcp_cpu_model (
    input  wire logic        clk,
    output var  logic [15:0] sfr_addr,
    output var  logic        sfr_wr,
    output var  logic        sfr_rd,
    output var  logic [7:0]  sfr_wdata,
    input  wire logic [7:0]  sfr_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sfr_addr  = 16'h0000;
        sfr_wr    = 1'b0;
        sfr_rd    = 1'b0;
        sfr_wdata = 8'h00;
    end
    task automatic wr8(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        @(posedge clk);
        sfr_wr    <= 1'b0;
        // Released data must not keep the old value
        sfr_wdata <= ~d;
    endtask
    task automatic rd8(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd   <= 1'b1;
        @(posedge clk);
        sfr_rd   <= 1'b0;
        @(negedge clk);
        d = sfr_rdata;
    endtask
    // Bytes are not latched, so a pair may tear
    task automatic rd16(input logic [15:0] a, output logic [15:0] v);
        rd8(a, v[7:0]);
        rd8(a + 16'h0001, v[15:8]);
    endtask
    task automatic prd16(input logic [7:0] p, input logic [15:0] a, output logic [15:0] v);
        wr8(`FCP_A_PAGE, p);
        rd16(a, v);
    endtask
    task automatic pwr16(input logic [7:0] p, input logic [15:0] a, input logic [15:0] v);
        wr8(`FCP_A_PAGE, p);
        wr8(a, v[7:0]);
        wr8(a + 16'h0001, v[15:8]);
    endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the forward current path and its registers.
// Assumes the processor model owns the register bus; samples come from here.
`include "fcp_cfg.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fcp_pkg::*;
    logic        clk;
    logic        resetn;
    logic [15:0] sfr_addr;
    logic        sfr_wr;
    logic        sfr_rd;
    logic [7:0]  sfr_wdata;
    logic [7:0]  sfr_rdata;
    logic        sample_valid;
    fcp_word_t   phase_a_in;
    fcp_word_t   phase_b_in;
    logic [15:0] rotor_angle;
    fcp_word_t   speed_loop_out;
    fcp_word_t   vd;
    fcp_word_t   vq;
    logic        voltage_valid;
    fcp_word_t   est_alpha;
    fcp_word_t   est_beta;
    logic        est_valid;
    logic [7:0]  mc1;
    logic [7:0]  foc;
    int          errors;
    int          n_checks;
    int          cycles;
    fcp_cpu_model cpu (.clk(clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));
    fcp_current_path dut (.clk(clk), .resetn(resetn), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .sample_valid(sample_valid), .phase_a_in(phase_a_in), .phase_b_in(phase_b_in),
        .rotor_angle(rotor_angle), .speed_loop_out(speed_loop_out),
        .d_axis_voltage(vd), .q_axis_voltage(vq), .voltage_valid(voltage_valid),
        .est_alpha(est_alpha), .est_beta(est_beta), .est_valid(est_valid),
        .motor_control_one(mc1), .field_oriented_control(foc));
    task automatic summarize();
        if (errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Tolerance covers one LSB of truncation in the rotation
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g, input bit t);
        n_checks++;
        if (!(g === e || (t && g === e - 16'h0001))) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic samp(input logic [15:0] a, input logic [15:0] b);
        @(posedge clk);
        phase_a_in   <= a;
        phase_b_in   <= b;
        sample_valid <= 1'b1;
        @(posedge clk);
        sample_valid <= 1'b0;
        @(posedge clk);
        #1;
        chk("est_valid", 16'h0001, {15'h0000, est_valid}, 1'b0);
        @(posedge clk);
        #1;
        chk("voltage_valid", 16'h0001, {15'h0000, voltage_valid}, 1'b0);
    endtask
    task automatic t_reset();
        logic [7:0]  b;
        logic [15:0] v;
        cpu.rd8(`FCP_A_MC1, b);
        chk("mc1", 16'h0000, {8'h00, b}, 1'b0);
        cpu.rd8(`FCP_A_FOC, b);
        chk("foc", 16'h0000, {8'h00, b}, 1'b0);
        chk("foc_out", 16'h0000, {mc1, foc}, 1'b0);
        cpu.prd16(`FCP_PAGE_D, `FCP_A_CMD_LO, v);
        chk("cmd_d", 16'h0000, v, 1'b0);
        cpu.prd16(`FCP_PAGE_Q, `FCP_A_CMD_LO, v);
        chk("cmd_q", 16'h0000, v, 1'b0);
    endtask
    task automatic t_cmd();
        logic [15:0] v;
        cpu.pwr16(`FCP_PAGE_D, `FCP_A_CMD_LO, 16'h1234);
        cpu.pwr16(`FCP_PAGE_Q, `FCP_A_CMD_LO, 16'h5678);
        cpu.pwr16(8'h02, `FCP_A_CMD_LO, 16'hbeef);
        cpu.prd16(8'h02, `FCP_A_CMD_LO, v);
        chk("cmd_p2", 16'h0000, v, 1'b0);
        cpu.prd16(`FCP_PAGE_D, `FCP_A_CMD_LO, v);
        chk("cmd_d", 16'h1234, v, 1'b0);
        cpu.prd16(`FCP_PAGE_Q, `FCP_A_CMD_LO, v);
        chk("cmd_q", 16'h5678, v, 1'b0);
        cpu.rd16(16'h1000, v);
        chk("unmapped", 16'h0000, v, 1'b0);
    endtask
    // Clear keeps the stored integral at zero; output is Kp*err plus one Ki*err step
    task automatic t_loop();
        logic [15:0] v;
        cpu.wr8(`FCP_A_FOC, 8'h80);
        samp(16'h0000, 16'h0000);
        chk("vd", 16'h051e, vd, 1'b0);
        chk("vq", 16'h1851, vq, 1'b0);
        cpu.prd16(`FCP_PAGE_Q, `FCP_A_OUT_LO, v);
        chk("out_q", 16'h1851, v, 1'b0);
        cpu.prd16(`FCP_PAGE_D, `FCP_A_OUT_LO, v);
        chk("out_d", 16'h051e, v, 1'b0);
        @(posedge clk);
        speed_loop_out <= 16'h0400;
        cpu.wr8(`FCP_A_MC1, 8'h10);
        samp(16'h0000, 16'h0000);
        chk("mc1_out", 16'h0010, {8'h00, mc1}, 1'b0);
        chk("vq_spd", 16'h0120, vq, 1'b0);
        // Zero speed output must zero vq even though the page-0 command is not zero
        @(posedge clk);
        speed_loop_out <= 16'h0000;
        samp(16'h0000, 16'h0000);
        chk("vq_spd0", 16'h0000, vq, 1'b0);
        cpu.wr8(`FCP_A_MC1, 8'h00);
    endtask
    task automatic t_clarke();
        logic [15:0] v;
        samp(16'h1000, 16'h0800);
        cpu.wr8(`FCP_A_PHA_LO, 8'hff);
        cpu.rd16(`FCP_A_PHA_LO, v);
        chk("phase_a", 16'h1000, v, 1'b0);
        cpu.rd16(`FCP_A_PHB_LO, v);
        chk("phase_b", 16'h0800, v, 1'b0);
        cpu.rd16(`FCP_A_ALPHA_LO, v);
        chk("alpha", 16'h1000, v, 1'b0);
        cpu.rd16(`FCP_A_BETA_LO, v);
        chk("beta", 16'h1279, v, 1'b0);
        cpu.prd16(`FCP_PAGE_Q, `FCP_A_FB_LO, v);
        chk("fb_q", 16'h1279, v, 1'b1);
        cpu.prd16(`FCP_PAGE_D, `FCP_A_FB_LO, v);
        chk("fb_d", 16'h1000, v, 1'b1);
    endtask
    // Codes 0..3 shift left with saturation, 4..7 shift right
    task automatic t_scale();
        int ea;
        int eb;
        for (int c = 0; c < 8; c++) begin
            ea = (c < 4) ? (32'h1000 << c) : (32'h1000 >> (c - 3));
            eb = (c < 4) ? (32'h093c << c) : (32'h093c >> (c - 3));
            ea = (ea > 32'h7fff) ? 32'h7fff : ea;
            eb = (eb > 32'h7fff) ? 32'h7fff : eb;
            cpu.wr8(`FCP_A_FOC, {1'b1, 3'(c), 4'h0});
            samp(16'h1000, 16'h0000);
            chk("foc_out", {9'h001, 3'(c), 4'h0}, {8'h00, foc}, 1'b0);
            chk("est_alpha", 16'(ea), est_alpha, 1'b0);
            chk("est_beta", 16'(eb), est_beta, 1'b0);
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            summarize();
        end
    end
    initial begin
        resetn         = 1'b0;
        sample_valid   = 1'b0;
        phase_a_in     = 16'h0000;
        phase_b_in     = 16'h0000;
        rotor_angle    = 16'h0000;
        speed_loop_out = 16'h0000;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_cmd();
        t_loop();
        t_clarke();
        t_scale();
        summarize();
    end
endmodule
`default_nettype wire
